// [hw/clock_gen.sv]
// Clock mode control, PLL lock wait and CPU clock dividers
`include "clock_gen_cfg.svh"
`default_nettype none
module clock_gen
  import clock_gen_pkg::*;
#(
  parameter logic [`LOCK_CNT_W-1:0] LOCK_WAIT_CYCLES = `LOCK_CNT_W'(`LOCK_WAIT_CYC)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic multiplier_select_bit0,
  input wire logic multiplier_select_bit1,
  input wire logic reference_clock_input,
  input wire logic pll_clock_input,
  output logic core_clock_out,
  output logic peripheral_clock_out,
  output logic quarter_rate_clock_out,
  output logic sixth_rate_clock_out,
  output logic eighth_rate_clock_out,
  output logic pll_locked,
  output logic mode_invalid,
  output logic [1:0] clock_mode
);

  // ----------------------------------------
  // Mode latch and lock sequencing
  // ----------------------------------------
  clk_state_t state_q;
  logic [1:0] mode_q;
  logic [`LOCK_CNT_W-1:0] lock_cnt_q;
  logic [1:0] pins;

  assign pins = {multiplier_select_bit1, multiplier_select_bit0};

  // Straps caught on first clock after reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_strap;
      mode_q <= `MODE_BYPASS;
    end else if (state_q == st_strap) begin
      mode_q <= pins;
      unique case (pins)
        `MODE_BYPASS: state_q <= st_bypass;
        `MODE_X6, `MODE_X12: state_q <= st_lock;
        default: state_q <= st_bad;
      endcase
    end else if (state_q == st_lock && lock_cnt_q == LOCK_WAIT_CYCLES - 1'b1) begin
      state_q <= st_run;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_q <= '0;
    end else if (state_q == st_lock) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end else begin
      lock_cnt_q <= '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pll_locked <= 1'b0;
      mode_invalid <= 1'b0;
      clock_mode <= `MODE_BYPASS;
    end else begin
      pll_locked <= (state_q == st_run);
      mode_invalid <= (state_q == st_bad);
      clock_mode <= mode_q;
    end
  end

  // ----------------------------------------
  // CPU clock source select
  // ----------------------------------------
  logic cpu_q;
  logic cpu_prev_q;
  logic cpu_rise;

  // Held low while straps settle, PLL locks, or mode is reserved
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_q <= 1'b0;
      cpu_prev_q <= 1'b0;
    end else begin
      cpu_prev_q <= cpu_q;
      if (state_q == st_bypass) begin
        cpu_q <= reference_clock_input;
      end else if (state_q == st_run) begin
        cpu_q <= pll_clock_input;
      end else begin
        cpu_q <= 1'b0;
      end
    end
  end

  assign cpu_rise = cpu_q & ~cpu_prev_q;
  assign core_clock_out = cpu_q;

  // ----------------------------------------
  // Dividers /2 /4 /6 /8
  // ----------------------------------------
  localparam logic [1:0] HALF [`DIV_COUNT] = '{`DIV2_HALF, `DIV4_HALF, `DIV6_HALF, `DIV8_HALF};
  logic [`DIV_COUNT-1:0] div_q;

  genvar i;
  generate
    for (i = 0; i < `DIV_COUNT; i++) begin : g_div
      logic [1:0] cnt_q;
      logic tog_q;
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          cnt_q <= 2'h0;
          tog_q <= 1'h0;
        end else if (cpu_rise) begin
          // Toggle every half period of CPU edges; /8 wraps 3 to 0
          if (cnt_q == HALF[i] - 2'h1) begin
            cnt_q <= 2'h0;
            tog_q <= ~tog_q;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
      end
      assign div_q[i] = tog_q;
    end
  endgenerate

  assign peripheral_clock_out = div_q[0];
  assign quarter_rate_clock_out = div_q[1];
  assign sixth_rate_clock_out = div_q[2];
  assign eighth_rate_clock_out = div_q[3];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence strap_zero_s;
    state_q == st_strap && pins == `MODE_BYPASS;
  endsequence

  sequence lock_start_s;
    state_q == st_strap && (pins == `MODE_X6 || pins == `MODE_X12);
  endsequence

  reserved_mode_halt_a: assert property (
    state_q == st_strap && pins == `MODE_RESERVED |=> state_q == st_bad ##1 mode_invalid
      && !cpu_q && !pll_locked)
    else $error("Reserved mode did not halt the clock");

  strap_bypass_a: assert property (
    strap_zero_s |=> state_q == st_bypass && !pll_locked)
    else $error("Low straps did not select bypass");

  bypass_route_a: assert property (
    state_q == st_bypass |=> cpu_q == $past(reference_clock_input))
    else $error("Bypass clock not routed from reference");

  pll_route_a: assert property (
    state_q == st_run |=> cpu_q == $past(pll_clock_input))
    else $error("Multiplied clock not routed from PLL");

  lock_hold_a: assert property (
    lock_start_s |=> (state_q == st_lock && !cpu_q) [*8])
    else $error("Multiplied clock used before lock wait");

  lock_length_a: assert property (
    state_q == st_lock && lock_cnt_q == LOCK_WAIT_CYCLES - 1'b1 |=> state_q == st_run
      ##1 pll_locked)
    else $error("Lock wait did not end at the full count");

  lock_bound_a: assert property (
    state_q == st_lock |-> lock_cnt_q < LOCK_WAIT_CYCLES)
    else $error("Lock counter overran its wait");

  half_rate_a: assert property (
    cpu_rise |=> peripheral_clock_out != $past(peripheral_clock_out))
    else $error("Half rate clock missed a CPU edge");

  sixth_step_a: assert property (
    $changed(sixth_rate_clock_out) |-> $past(cpu_rise) && $past(g_div[2].cnt_q) == 2'h2)
    else $error("Sixth rate clock toggled off its count");

  quarter_step_a: assert property (
    $changed(quarter_rate_clock_out) |-> $past(cpu_rise) && $past(g_div[1].cnt_q) == 2'h1)
    else $error("Quarter rate clock toggled off its count");

  eighth_step_a: assert property (
    $changed(eighth_rate_clock_out) |-> $past(cpu_rise) && $past(g_div[3].cnt_q) == 2'h3)
    else $error("Eighth rate clock toggled off its count");

  divider_idle_a: assert property (
    !cpu_rise |=> $stable(div_q))
    else $error("Divider moved without a CPU edge");

  bypass_unlocked_a: assert property (
    state_q == st_bypass |-> !pll_locked && lock_cnt_q == '0)
    else $error("Bypass mode waited for lock");

  lock_early_a: assert property (
    state_q == st_lock && lock_cnt_q != LOCK_WAIT_CYCLES - 1'b1 |=> state_q == st_lock)
    else $error("Lock wait ended before the full count");

  stopped_clock_a: assert property (
    state_q inside {st_strap, st_lock, st_bad} |=> !cpu_q)
    else $error("CPU clock ran without a valid source");

  reserved_stays_a: assert property (
    state_q == st_bad |=> state_q == st_bad && mode_invalid)
    else $error("Reserved mode left its halt");

  strap_latch_a: assert property (
    state_q != st_strap |=> $stable(mode_q) && clock_mode == mode_q)
    else $error("Strap code changed after it was latched");

  run_locked_a: assert property (
    state_q == st_run |=> pll_locked && !mode_invalid)
    else $error("Run state without lock flag");

  bypass_code_a: assert property (
    state_q == st_bypass |-> mode_q == `MODE_BYPASS)
    else $error("Bypass entered from a non-bypass code");

endmodule
`default_nettype wire

// [hw/clock_gen_cfg.svh]
// Constants of the clock generation block
// What this block does
// - Select pins pick bypass, x6, x12; 11 invalid
// - Bypass routes reference; multiply routes PLL clock
// - Divide CPU clock by two, four, six, eight
// - Deliver generated clocks to core and peripherals
// - Wait PLL lock time only in multiply modes
// - Lock wait covers two and half typical
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

// ----------------------------------------
// Select pin codes
// ----------------------------------------
`define MODE_BYPASS 2'h0
`define MODE_X6 2'h1
`define MODE_X12 2'h2
`define MODE_RESERVED 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define LOCK_TYP_NS 75000
`define LOCK_MARGIN_NUM 5
`define LOCK_MARGIN_DEN 2
`define LOCK_WAIT_NS (`LOCK_TYP_NS * `LOCK_MARGIN_NUM / `LOCK_MARGIN_DEN)
`define LOCK_WAIT_CYC ((`LOCK_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_CNT_W 16

// ----------------------------------------
// Dividers: half period in CPU rising edges
// ----------------------------------------
`define DIV_COUNT 4
`define DIV2_HALF 2'h1
`define DIV4_HALF 2'h2
`define DIV6_HALF 2'h3
`define DIV8_HALF 2'h0

`endif

// [hw/clock_gen_pkg.sv]
// Types of the clock generation block
`default_nettype none
package clock_gen_pkg;
  typedef enum logic [2:0] {
    st_strap,
    st_bypass,
    st_lock,
    st_run,
    st_bad
  } clk_state_t;
endpackage
`default_nettype wire

// [verification/board_model.sv]
// Board model: reference oscillator and PLL output
`default_nettype none
module board_model (
  input wire logic mclk,
  input wire logic [2:0] ref_half,
  output logic reference_clock_input,
  output logic pll_clock_input
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial reference_clock_input = 1'b0;
  initial pll_clock_input = 1'b0;
  always @(posedge mclk) begin
    #1;
    pll_clock_input <= ~pll_clock_input;
    cnt <= (cnt + 1 >= ref_half) ? 0 : cnt + 1;
    if (cnt + 1 >= ref_half) reference_clock_input <= ~reference_clock_input;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench of the clock generation block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCKN = 20;
  logic mclk = 1'b0, rstn = 1'b0, sel0 = 1'b0, sel1 = 1'b0, ref_d = 1'b0, last = 1'b0;
  logic core, per, quar, sixth, eighth, locked, inval, ref_clk, pll_clk, fin;
  logic [1:0] cmode;
  logic pll_d = 1'b0;
  int mode_n = 0;
  logic [2:0] ref_half = 3'h2;
  logic [4:0] now_v, prev_v, rise;
  logic [31:0] exp_q[$];
  int num_errors = 0, check_count = 0, cyc, lock_at, cnt[5];
  always #5 mclk = ~mclk;
  clock_gen #(.LOCK_WAIT_CYCLES(16'(LOCKN))) i_clock_gen (.mclk(mclk), .rstn(rstn),
    .multiplier_select_bit0(sel0), .multiplier_select_bit1(sel1),
    .reference_clock_input(ref_clk), .pll_clock_input(pll_clk), .core_clock_out(core),
    .peripheral_clock_out(per), .quarter_rate_clock_out(quar),
    .sixth_rate_clock_out(sixth), .eighth_rate_clock_out(eighth), .pll_locked(locked),
    .mode_invalid(inval), .clock_mode(cmode));
  board_model i_board_model (.mclk(mclk), .ref_half(ref_half),
    .reference_clock_input(ref_clk), .pll_clock_input(pll_clk));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Watcher: divider edge counts and lock time
  // ----------------------------------------
  always @(negedge mclk) begin
    now_v = {core, eighth, sixth, quar, per};
    rise = now_v & ~prev_v;
    prev_v = now_v;
    if (!rstn) begin
      cyc = 0; lock_at = 0; fin = 1'b0; last = 1'b0;
      foreach (cnt[i]) cnt[i] = 0;
    end else begin
      cyc++;
      if (locked === 1'b1 && lock_at == 0) lock_at = cyc;
      if (mode_n == 0 && cyc >= 3) chk(32'(core), 32'(ref_d));
      if (mode_n != 0 && cyc >= 3) begin
        chk(32'(core), (mode_n != 3 && cyc >= LOCKN + 3) ? 32'(pll_d) : 32'h0);
      end
      if (cyc > LOCKN + 3 && !fin) begin
        for (int i = 0; i < 4; i++) if (cyc > LOCKN + 4 && rise[i]) cnt[i]++;
        if (last || cyc == LOCKN + 400) begin
          fin = 1'b1;
          chk(32'(cmode), exp_q.pop_front());
          chk(32'(inval), exp_q.pop_front());
          chk(32'(lock_at), exp_q.pop_front());
          for (int i = 0; i < 5; i++) chk(32'(cnt[i]), exp_q.pop_front());
        end
        if (rise[4] && cnt[4] < 24) begin
          cnt[4]++;
          last = (cnt[4] == 24);
        end
      end
    end
    ref_d = ref_clk;
    pll_d = pll_clk;
  end
  // ----------------------------------------
  // Driver: one reset per strap code
  // ----------------------------------------
  initial begin
    void'($urandom(32'hF93E));
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      #1 rstn = 1'b0;
      {sel1, sel0} = 2'(m);
      mode_n = m;
      ref_half = 3'(2 + $urandom % 4);
      exp_q.push_back(32'(m));
      exp_q.push_back(32'(m == 3));
      // Lock seen one watcher step after the edge that raises it
      exp_q.push_back((m == 1 || m == 2) ? 32'(LOCKN + 3) : 32'h0);
      foreach (cnt[i]) begin
        exp_q.push_back((m == 3) ? 32'h0 : (i == 4) ? 32'h18 : 32'(24 / (2 + 2 * i)));
      end
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge mclk);
      #1 {sel1, sel0} = 2'($urandom);
      for (int w = 0; w < 600 && !fin; w++) @(posedge mclk);
      if (!fin) begin
        num_errors++;
        break;
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
